// ===== core/ccdo_pkg.sv
// package: opcodes, widths and reset values for the clear/call/decrement executor
package ccdo_pkg;
  localparam int FILE_ADDR_W = 7;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 15;
  localparam int PC_LO_W     = 8;
  localparam int PC_HI_W     = 7;
  localparam int LATCH_W     = 8;
  localparam int WDT_W       = 8;
  localparam int WDT_PRE_W   = 8;

  localparam logic [DATA_W-1:0]    ZERO_BYTE     = 8'h00;
  localparam logic [DATA_W-1:0]    ONE_BYTE      = 8'h01;
  localparam logic [PC_W-1:0]      PC_STEP       = 15'h0001;
  localparam logic [PC_W-1:0]      PC_RESET      = 15'h0000;
  localparam logic [WDT_W-1:0]     WDT_CLEAR     = 8'h00;
  localparam logic [WDT_PRE_W-1:0] WDT_PRE_CLEAR = 8'h00;
  localparam logic                 DEST_ACC      = 1'b0;
  localparam logic                 DEST_FILE     = 1'b1;
  localparam logic                 FLAG_N_SET    = 1'b1;

  typedef enum logic [2:0] {
    CCDO_OP_NONE,
    CCDO_OP_CALL_ACC,
    CCDO_OP_CLR_FILE,
    CCDO_OP_CLR_ACC,
    CCDO_OP_KICK_WDT,
    CCDO_OP_INV_FILE,
    CCDO_OP_DEC_FILE
  } ccdo_op_e;

  typedef enum logic [1:0] {
    CCDO_ST_IDLE,
    CCDO_ST_CALL2
  } ccdo_state_e;
endpackage

// ===== core/ccdo_alu_if.sv
// interface: operand and result path between the executor and its alu
`timescale 1ns/1ps
interface ccdo_alu_if;
  import ccdo_pkg::*;
  ccdo_op_e          op;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic              result_zero;
  modport ctrl (output op, output operand, input result, input result_zero);
  modport alu  (input op, input operand, output result, output result_zero);
endinterface

// ===== core/ccdo_alu.sv
// combinational alu for clear, invert and decrement
`timescale 1ns/1ps
module ccdo_alu
  import ccdo_pkg::*;
(
  ccdo_alu_if.alu a
);
  always_comb begin
    case (a.op)
      CCDO_OP_CLR_FILE,
      CCDO_OP_CLR_ACC:  a.result = ZERO_BYTE;
      CCDO_OP_INV_FILE: a.result = ~a.operand;
      CCDO_OP_DEC_FILE: a.result = a.operand - ONE_BYTE;
      default:          a.result = a.operand;
    endcase
    a.result_zero = (a.result == ZERO_BYTE);
  end
endmodule

// ===== core/ccdo_exec.sv
// executor for call-via-acc, clears, watchdog kick, invert and decrement
`timescale 1ns/1ps

// Functional notes
// - A call via the accumulator pushes the current pc plus one onto the return stack.
// - That call loads the accumulator into pc bits 7..0 and latch bits 6..0 into pc 14..8.
// - That call takes two cycles, has no operand and leaves all status flags alone.
// - Clearing a file register writes zero to the 7-bit addressed register and sets zero.
// - Clearing the accumulator writes zero to it and sets the zero flag.
// - A watchdog kick resets the watchdog counter to zero.
// - A watchdog kick also clears the watchdog prescaler.
// - A watchdog kick sets both active-low expiry and sleep flags to one.
// - Invert complements the register, to accumulator if dest is 0, else back to the file.
// - Decrement subtracts one, to accumulator if dest is 0, else back to the file.
module ccdo_exec
  import ccdo_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   instr_valid,
  input  wire ccdo_op_e               instr_op,
  input  wire logic [FILE_ADDR_W-1:0] instr_file_addr,
  input  wire logic                   instr_dest,
  input  wire logic [DATA_W-1:0]      file_rdata,
  input  wire logic [DATA_W-1:0]      acc_in,
  input  wire logic [LATCH_W-1:0]     upper_pc_latch,
  input  wire logic [PC_W-1:0]        pc_in,
  output logic                        busy,
  output logic                        done,
  output logic [FILE_ADDR_W-1:0]      file_addr,
  output logic                        file_we,
  output logic [DATA_W-1:0]           file_wdata,
  output logic                        acc_we,
  output logic [DATA_W-1:0]           acc_wdata,
  output logic                        zero_we,
  output logic                        zero_flag,
  output logic                        stack_push,
  output logic [PC_W-1:0]             stack_top,
  output logic                        pc_load,
  output logic [PC_W-1:0]             pc_target,
  output logic                        wdt_clear,
  output logic [WDT_W-1:0]            wdt_count_value,
  output logic [WDT_PRE_W-1:0]        wdt_prescaler_value,
  output logic                        status_we_n_flags,
  output logic                        watchdog_expiry_flag_n,
  output logic                        sleep_entered_flag_n
);
  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    ccdo_state_e                 st;
    logic                        busy;
    logic                        done;
    logic [FILE_ADDR_W-1:0]      file_addr;
    logic                        file_we;
    logic [DATA_W-1:0]           file_wdata;
    logic                        acc_we;
    logic [DATA_W-1:0]           acc_wdata;
    logic                        zero_we;
    logic                        zero_flag;
    logic                        stack_push;
    logic [PC_W-1:0]             stack_top;
    logic                        pc_load;
    logic [PC_W-1:0]             pc_target;
    logic                        wdt_clear;
    // watchdog load values, meaningful only with wdt_clear
    logic [WDT_W-1:0]            wdt_count;
    logic [WDT_PRE_W-1:0]        wdt_pre;
    logic                        flags_we;
    // values for the two active-low status flags, meaningful only with flags_we
    logic                        expiry_n;
    logic                        sleep_n;
  } ccdo_state_s;

  ccdo_state_s state_reg;
  ccdo_state_s state_next;

  // ----------------------------------------------------------------
  // alu: operand comes straight from the file read port
  // ----------------------------------------------------------------
  ccdo_alu_if alu_bus ();
  ccdo_alu u_alu (.a(alu_bus));

  assign alu_bus.op      = instr_op;
  assign alu_bus.operand = file_rdata;

  // ----------------------------------------------------------------
  // call addresses, formed in the cycle the call is taken
  // ----------------------------------------------------------------
  logic [PC_W-1:0] return_addr;
  logic [PC_W-1:0] call_target;

  assign return_addr = pc_in + PC_STEP;
  assign call_target = {upper_pc_latch[PC_HI_W-1:0], acc_in[PC_LO_W-1:0]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.done       = 1'b0;
    state_next.file_we    = 1'b0;
    state_next.acc_we     = 1'b0;
    state_next.zero_we    = 1'b0;
    state_next.stack_push = 1'b0;
    state_next.pc_load    = 1'b0;
    state_next.wdt_clear  = 1'b0;
    state_next.flags_we   = 1'b0;
    case (state_reg.st)
      CCDO_ST_IDLE: begin
        state_next.busy = 1'b0;
        // single-cycle ops answer on the next edge
        if (instr_valid) begin
          case (instr_op)
            CCDO_OP_CALL_ACC: begin
              state_next.stack_push = 1'b1;
              state_next.stack_top  = return_addr;
              state_next.pc_target  = call_target;
              state_next.busy       = 1'b1;
              state_next.st         = CCDO_ST_CALL2;
            end
            CCDO_OP_CLR_FILE: begin
              state_next.file_addr  = instr_file_addr;
              state_next.file_we    = 1'b1;
              state_next.file_wdata = alu_bus.result;
              state_next.zero_we    = 1'b1;
              state_next.zero_flag  = 1'b1;
              state_next.done       = 1'b1;
            end
            CCDO_OP_CLR_ACC: begin
              state_next.acc_we     = 1'b1;
              state_next.acc_wdata  = alu_bus.result;
              state_next.zero_we    = 1'b1;
              state_next.zero_flag  = 1'b1;
              state_next.done       = 1'b1;
            end
            CCDO_OP_KICK_WDT: begin
              state_next.wdt_clear  = 1'b1;
              state_next.wdt_count  = WDT_CLEAR;
              state_next.wdt_pre    = WDT_PRE_CLEAR;
              state_next.flags_we   = 1'b1;
              state_next.expiry_n   = FLAG_N_SET;
              state_next.sleep_n    = FLAG_N_SET;
              state_next.done       = 1'b1;
            end
            CCDO_OP_INV_FILE,
            CCDO_OP_DEC_FILE: begin
              state_next.file_addr  = instr_file_addr;
              if (instr_dest == DEST_FILE) begin
                state_next.file_we    = 1'b1;
                state_next.file_wdata = alu_bus.result;
              end else begin
                state_next.acc_we     = 1'b1;
                state_next.acc_wdata  = alu_bus.result;
              end
              state_next.zero_we    = 1'b1;
              state_next.zero_flag  = alu_bus.result_zero;
              state_next.done       = 1'b1;
            end
            // unknown codes change nothing
            default: state_next.done = 1'b0;
          endcase
        end
      end
      CCDO_ST_CALL2: begin
        // second cycle: redirect pc, no status flag touched
        // an instruction offered now is dropped; decode must hold it
        state_next.pc_load = 1'b1;
        state_next.done    = 1'b1;
        state_next.busy    = 1'b0;
        state_next.st      = CCDO_ST_IDLE;
      end
      default: state_next.st = CCDO_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      // pulses low, data zero, active-low flags high
      state_reg            <= '0;
      state_reg.st         <= CCDO_ST_IDLE;
      state_reg.stack_top  <= PC_RESET;
      state_reg.pc_target  <= PC_RESET;
      state_reg.expiry_n   <= FLAG_N_SET;
      state_reg.sleep_n    <= FLAG_N_SET;
      state_reg.wdt_count  <= WDT_CLEAR;
      state_reg.wdt_pre    <= WDT_PRE_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy                   = state_reg.busy;
  assign done                   = state_reg.done;
  assign file_addr              = state_reg.file_addr;
  assign file_we                = state_reg.file_we;
  assign file_wdata             = state_reg.file_wdata;
  assign acc_we                 = state_reg.acc_we;
  assign acc_wdata              = state_reg.acc_wdata;
  assign zero_we                = state_reg.zero_we;
  assign zero_flag              = state_reg.zero_flag;
  assign stack_push             = state_reg.stack_push;
  assign stack_top              = state_reg.stack_top;
  assign pc_load                = state_reg.pc_load;
  assign pc_target              = state_reg.pc_target;
  assign wdt_clear              = state_reg.wdt_clear;
  assign wdt_count_value        = state_reg.wdt_count;
  assign wdt_prescaler_value    = state_reg.wdt_pre;
  assign status_we_n_flags      = state_reg.flags_we;
  assign watchdog_expiry_flag_n = state_reg.expiry_n;
  assign sleep_entered_flag_n   = state_reg.sleep_n;
endmodule

// ===== bench/ccdo_exec_props.sv
// checker: concurrent properties on the executor ports
`timescale 1ns/1ps
module ccdo_exec_props
  import ccdo_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   instr_valid,
  input wire ccdo_op_e               instr_op,
  input wire logic [FILE_ADDR_W-1:0] instr_file_addr,
  input wire logic                   instr_dest,
  input wire logic [DATA_W-1:0]      file_rdata,
  input wire logic [DATA_W-1:0]      acc_in,
  input wire logic [LATCH_W-1:0]     upper_pc_latch,
  input wire logic [PC_W-1:0]        pc_in,
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic [FILE_ADDR_W-1:0] file_addr,
  input wire logic                   file_we,
  input wire logic [DATA_W-1:0]      file_wdata,
  input wire logic                   acc_we,
  input wire logic [DATA_W-1:0]      acc_wdata,
  input wire logic                   zero_we,
  input wire logic                   zero_flag,
  input wire logic                   stack_push,
  input wire logic [PC_W-1:0]        stack_top,
  input wire logic                   pc_load,
  input wire logic [PC_W-1:0]        pc_target,
  input wire logic                   wdt_clear,
  input wire logic [WDT_W-1:0]       wdt_count_value,
  input wire logic [WDT_PRE_W-1:0]   wdt_prescaler_value,
  input wire logic                   status_we_n_flags,
  input wire logic                   watchdog_expiry_flag_n,
  input wire logic                   sleep_entered_flag_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take(ccdo_op_e o);
    instr_valid && !busy && instr_op == o;
  endsequence
  sequence s_wr(logic we, logic [7:0] v, logic [7:0] e);
    we && v == e && zero_we;
  endsequence
  chk_call_push: assert property (
    s_take(CCDO_OP_CALL_ACC) |=> stack_push && busy && stack_top == $past(pc_in) + PC_STEP)
    else $error("call push wrong");
  chk_call_target: assert property (
    s_take(CCDO_OP_CALL_ACC) |-> ##2 pc_load && pc_target[7:0] == $past(acc_in, 2)
    && {1'h0, pc_target[14:8]} == ($past(upper_pc_latch, 2) & 8'h7f)) else $error("call target");
  chk_call_flags: assert property (
    s_take(CCDO_OP_CALL_ACC) |=> !zero_we && !done ##1 !zero_we && done && !busy)
    else $error("call flags or length");
  chk_clr_file: assert property (s_take(CCDO_OP_CLR_FILE) |=>
    s_wr(file_we, file_wdata, 8'h00) ##0 zero_flag && file_addr == $past(instr_file_addr))
    else $error("clear file wrong");
  chk_clr_acc: assert property (s_take(CCDO_OP_CLR_ACC) |=>
    s_wr(acc_we, acc_wdata, 8'h00) ##0 zero_flag) else $error("clear acc wrong");
  chk_kick_wdt: assert property (s_take(CCDO_OP_KICK_WDT) |=> wdt_clear
    && wdt_count_value == WDT_CLEAR && wdt_prescaler_value == WDT_PRE_CLEAR) else $error("kick");
  chk_kick_flags: assert property (s_take(CCDO_OP_KICK_WDT) |=> status_we_n_flags
    && watchdog_expiry_flag_n && sleep_entered_flag_n) else $error("kick flags wrong");
  chk_inv_result: assert property (s_take(CCDO_OP_INV_FILE) |=>
    s_wr(1'h1, $past(instr_dest) ? file_wdata : acc_wdata, ~$past(file_rdata)) ##0
    file_we == $past(instr_dest) && zero_flag == ($past(file_rdata) == 8'hff)) else $error("inv");
  chk_dec_result: assert property (s_take(CCDO_OP_DEC_FILE) |=>
    s_wr(1'h1, $past(instr_dest) ? file_wdata : acc_wdata, $past(file_rdata) - 8'h01) ##0
    acc_we != $past(instr_dest) && zero_flag == ($past(file_rdata) == 8'h01)) else $error("dec");
  chk_single_done: assert property (instr_valid && !busy && instr_op inside
    {CCDO_OP_CLR_FILE, CCDO_OP_CLR_ACC, CCDO_OP_KICK_WDT, CCDO_OP_INV_FILE, CCDO_OP_DEC_FILE}
    |=> done && !busy) else $error("single cycle op not done");
endmodule
bind ccdo_exec ccdo_exec_props i_ccdo_exec_props (.clock, .rst, .instr_valid, .instr_op,
  .instr_file_addr, .instr_dest, .file_rdata, .acc_in, .upper_pc_latch, .pc_in, .busy, .done,
  .file_addr, .file_we, .file_wdata, .acc_we, .acc_wdata, .zero_we, .zero_flag, .stack_push,
  .stack_top, .pc_load, .pc_target, .wdt_clear, .wdt_count_value, .wdt_prescaler_value,
  .status_we_n_flags, .watchdog_expiry_flag_n, .sleep_entered_flag_n);

// ===== bench/cpu_clear_call_decrement_ops_bench.sv
// bench: directed scenarios for the clear/call/decrement executor
`timescale 1ns/1ps
module cpu_clear_call_decrement_ops_bench;
  import ccdo_pkg::*;
  logic                   clock, rst, instr_valid, instr_dest, busy, done, file_we, acc_we;
  logic                   zero_we, zero_flag, stack_push, pc_load, wdt_clear, status_we_n_flags;
  logic                   watchdog_expiry_flag_n, sleep_entered_flag_n;
  ccdo_op_e               instr_op;
  logic [FILE_ADDR_W-1:0] instr_file_addr, file_addr;
  logic [DATA_W-1:0]      file_rdata, acc_in, file_wdata, acc_wdata, wdt_count_value, wdt_pre;
  logic [LATCH_W-1:0]     upper_pc_latch;
  logic [PC_W-1:0]        pc_in, stack_top, pc_target;
  int                     n_errors = 0;
  int                     cmp_count = 0;
  ccdo_exec i_ccdo_exec (.clock, .rst, .instr_valid, .instr_op, .instr_file_addr, .instr_dest,
    .file_rdata, .acc_in, .upper_pc_latch, .pc_in, .busy, .done, .file_addr, .file_we,
    .file_wdata, .acc_we, .acc_wdata, .zero_we, .zero_flag, .stack_push, .stack_top, .pc_load,
    .pc_target, .wdt_clear, .wdt_count_value, .wdt_prescaler_value(wdt_pre), .status_we_n_flags,
    .watchdog_expiry_flag_n, .sleep_entered_flag_n);
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // issue one op at a falling edge, return half a cycle after it is taken
  task automatic go(input ccdo_op_e o, input logic [6:0] a, input logic [7:0] f, input logic d);
    @(negedge clock);
    instr_valid = 1'h1;
    instr_op = o;
    instr_file_addr = a;
    file_rdata = f;
    instr_dest = d;
    @(negedge clock);
    instr_valid = 1'h0;
  endtask
  task automatic t_clear();
    // preload file data with a non-zero value and the zero flag with 0 so the clear must change them
    go(CCDO_OP_INV_FILE, 7'h11, 8'h3c, 1'h1);
    go(CCDO_OP_CLR_FILE, 7'h7f, 8'h3c, 1'h0);
    chk("file_write", {file_we, file_addr, file_wdata}, 16'hff00);
    chk("zero", {zero_we, zero_flag, done}, 3'h7);
    go(CCDO_OP_INV_FILE, 7'h00, 8'h3c, 1'h0);
    go(CCDO_OP_CLR_ACC, 7'h00, 8'h3c, 1'h0);
    chk("acc_write", {acc_we, acc_wdata, zero_we, zero_flag}, 11'h403);
    $display("test clear done");
  endtask
  task automatic t_kick();
    go(CCDO_OP_KICK_WDT, 7'h01, 8'h00, 1'h0);
    chk("wdt", {wdt_clear, wdt_count_value}, 9'h100);
    chk("wdt_pre", wdt_pre, 8'h00);
    chk("expiry_n", {status_we_n_flags, watchdog_expiry_flag_n}, 2'h3);
    chk("sleep_n", {status_we_n_flags, sleep_entered_flag_n}, 2'h3);
    chk("done", done, 1'h1);
    $display("test kick done");
  endtask
  task automatic t_alu();
    logic [7:0] f [4] = '{8'hff, 8'h5a, 8'h00, 8'h01};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r = (i < 2) ? ~f[i] : f[i] - 8'h01;
      go((i < 2) ? CCDO_OP_INV_FILE : CCDO_OP_DEC_FILE, 7'h20, f[i], i[0]);
      chk("dest", {file_we, acc_we}, i[0] ? 2'h2 : 2'h1);
      chk("result", i[0] ? file_wdata : acc_wdata, r);
      chk("zero", {zero_we, zero_flag}, {1'h1, r == 8'h00});
    end
    $display("test invert decrement done");
  endtask
  task automatic t_call();
    pc_in = 15'h7ffe;
    upper_pc_latch = 8'hd5;
    acc_in = 8'h3c;
    @(negedge clock);
    instr_valid = 1'h1;
    instr_op = CCDO_OP_CALL_ACC;
    @(negedge clock);
    // offered while busy: must be dropped
    instr_op = CCDO_OP_CLR_ACC;
    chk("push", {stack_push, busy, pc_load, zero_we}, 4'hc);
    chk("stack_top", stack_top, 15'h7fff);
    @(negedge clock);
    instr_valid = 1'h0;
    chk("pc_target", pc_target, 15'h553c);
    chk("end", {pc_load, done, busy, zero_we, acc_we}, 5'h18);
    $display("test call done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #20us;
    n_errors++;
    $display("Error watchdog expected finish seen hang");
    give_verdict();
  end
  initial begin
    rst             = 1'h1;
    instr_valid     = 1'h0;
    instr_dest      = 1'h0;
    instr_op        = CCDO_OP_NONE;
    instr_file_addr = 7'h00;
    {file_rdata, acc_in, upper_pc_latch, pc_in} = {8'h00, 8'h5a, 8'h00, 15'h0000};
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'h0;
    t_clear();
    t_kick();
    t_alu();
    t_call();
    give_verdict();
  end
endmodule
